// ---- timer16_front.v ----
// 16-bit timer front-end: byte access, clock select, compare, capture, flags
`timescale 1ns/1ps
`include "timer16_defines.vh"
module timer16_front (
   input wire clock,
   input wire rst,
   input wire [5:0] io_addr,
   input wire io_wr,
   input wire io_rd,
   input wire [7:0] io_wdata,
   input wire external_timer_clock_pin,
   input wire capture_input_pin,
   input wire comparator_out,
   input wire capture_from_comparator,
   output reg [7:0] io_rdata,
   output reg compare_output_a,
   output reg compare_output_b,
   output reg [7:0] timer_flag_register,
   output reg [7:0] timer_mask_register,
   output reg [7:0] special_function_io_control,
   output reg irq_overflow,
   output reg irq_compare_a,
   output reg irq_compare_b,
   output reg irq_capture
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] temp_high;
   reg [7:0] timer_control_a;
   reg [7:0] timer_control_b;
   reg [15:0] counter_value16;
   reg [15:0] compare_register_a;
   reg [15:0] compare_register_b;
   reg [15:0] cmp_a_buf;
   reg [15:0] cmp_b_buf;
   reg [15:0] capture_register;
   reg psr_pulse;
   reg ext_s1;
   reg ext_s2;
   reg ext_q;
   wire tap8;
   wire tap64;
   wire tap256;
   wire tap1024;
   wire cap_event;
   wire [2:0] clock_select_field = timer_control_b[2:0];
   wire [3:0] waveform_mode_field = {timer_control_b[4:3], timer_control_a[1:0]};
   wire wr = io_wr;
   wire wr_psr = wr && (io_addr == `ADDR_SFIO) && io_wdata[`BIT_PSR];
   // ----------------------------------------
   // prescaler and filter
   // ----------------------------------------
   shared_prescaler u_presc (
      .clock(clock),
      .rst(rst),
      .restart(psr_pulse),
      .tap8(tap8),
      .tap64(tap64),
      .tap256(tap256),
      .tap1024(tap1024)
   );
   capture_filter #(.LEN(`FILTER_LEN)) u_capf (
      .clock(clock),
      .rst(rst),
      .level_in(capture_from_comparator ? comparator_out : capture_input_pin), // RL9
      .filter_on(timer_control_b[`BIT_ICNC]),
      .rising(timer_control_b[`BIT_ICES]),
      .event_out(cap_event)
   );
   // ----------------------------------------
   // clock select
   // ----------------------------------------
   // first sync flop feeds only the second; edge is taken on later stages
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_q <= 1'b0;
      end else begin
         ext_s1 <= external_timer_clock_pin;
         ext_s2 <= ext_s1;
         ext_q <= ext_s2;
      end
   end
   reg timer_tick;
   always @* begin
      case (clock_select_field) // RL5
         `CS_NONE: timer_tick = 1'b0; // RL6
         `CS_DIV1: timer_tick = 1'b1;
         `CS_DIV8: timer_tick = tap8;
         `CS_DIV64: timer_tick = tap64;
         `CS_DIV256: timer_tick = tap256;
         `CS_DIV1024: timer_tick = tap1024;
         `CS_EXT_FALL: timer_tick = ~ext_s2 & ext_q; // RL23
         `CS_EXT_RISE: timer_tick = ext_s2 & ~ext_q; // RL23
         default: timer_tick = 1'b0;
      endcase
   end
   // ----------------------------------------
   // top selection
   // ----------------------------------------
   reg [15:0] top_value;
   reg top_from_a;
   reg buffered;
   always @* begin
      top_from_a = 1'b0;
      buffered = 1'b1;
      case (waveform_mode_field) // RL12
         4'h1, 4'h5: top_value = `TOP_8;
         4'h2, 4'h6: top_value = `TOP_9;
         4'h3, 4'h7: top_value = `TOP_10;
         4'h4: begin
            top_value = cmp_a_buf;
            buffered = 1'b0;
         end
         4'h9, 4'hB, 4'hF: begin
            top_value = cmp_a_buf;
            top_from_a = 1'b1; // RL13
         end
         4'h8, 4'hA, 4'hE: top_value = capture_register;
         4'hC: begin
            top_value = capture_register;
            buffered = 1'b0;
         end
         4'h0: begin
            top_value = `MAX;
            buffered = 1'b0;
         end
         default: top_value = `MAX;
      endcase
   end
   wire at_bottom = (counter_value16 == `BOTTOM); // RL11
   wire at_max = (counter_value16 == `MAX); // RL11
   wire at_top = (counter_value16 == top_value);
   wire cnt_low_wr = wr && (io_addr == `ADDR_CNT_L);
   wire match_a = (counter_value16 == compare_register_a); // RL7
   wire match_b = (counter_value16 == compare_register_b); // RL7
   wire ovf = timer_tick && (waveform_mode_field == 4'h0 ? at_max : at_top);
   // ----------------------------------------
   // counter, buffers, capture
   // ----------------------------------------
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         counter_value16 <= `BOTTOM;
         compare_register_a <= `BOTTOM;
         compare_register_b <= `BOTTOM;
         cmp_a_buf <= `BOTTOM;
         cmp_b_buf <= `BOTTOM;
         capture_register <= `BOTTOM;
         temp_high <= `RESET_BYTE;
         timer_control_a <= `RESET_BYTE;
         timer_control_b <= `RESET_BYTE;
         timer_mask_register <= `RESET_BYTE;
         special_function_io_control <= `RESET_BYTE;
         psr_pulse <= 1'b0;
      end else begin
         psr_pulse <= wr_psr; // RL1 RL2
         if (cnt_low_wr) begin
            counter_value16 <= {temp_high, io_wdata}; // RL15
         end else if (timer_tick) begin // RL6
            if (at_top || (waveform_mode_field == 4'h0 && at_max)) begin
               counter_value16 <= `BOTTOM;
            end else begin
               counter_value16 <= counter_value16 + 16'h0001;
            end
         end
         // compare registers load from the buffers at top; in modes 0, 4 and 12 they load every cycle
         if (!buffered || (timer_tick && at_top)) begin // RL13
            compare_register_a <= cmp_a_buf;
            compare_register_b <= cmp_b_buf;
         end
         if (cap_event && !top_from_a && waveform_mode_field[3:2] != 2'b11) begin
            capture_register <= counter_value16; // RL9
         end
         if (wr) begin
            case (io_addr)
               `ADDR_CNT_H, `ADDR_CMPA_H, `ADDR_CMPB_H, `ADDR_CAP_H:
                  temp_high <= io_wdata; // RL14 RL25
               `ADDR_CMPA_L: cmp_a_buf <= {temp_high, io_wdata}; // RL15
               `ADDR_CMPB_L: cmp_b_buf <= {temp_high, io_wdata}; // RL15
               `ADDR_CAP_L: capture_register <= {temp_high, io_wdata}; // RL15
               `ADDR_CTRL_A: timer_control_a <= io_wdata; // RL21
               `ADDR_CTRL_B: timer_control_b <= io_wdata; // RL21
               `ADDR_MASK: timer_mask_register <= io_wdata; // RL20
               `ADDR_SFIO: special_function_io_control <= {io_wdata[7:1], 1'b0}; // RL3
               default: ;
            endcase
         end else if (io_rd) begin
            case (io_addr)
               `ADDR_CNT_L: temp_high <= counter_value16[15:8]; // RL16
               `ADDR_CAP_L: temp_high <= capture_register[15:8]; // RL16
               default: ;
            endcase
         end
      end
   end
   // ----------------------------------------
   // flags: set wins over write-one clear
   // ----------------------------------------
   wire flag_wr = wr && (io_addr == `ADDR_FLAG);
   wire [7:0] set_vec = {2'b00, cap_event, match_a && timer_tick, match_b && timer_tick,
                         ovf, 2'b00};
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         timer_flag_register <= `RESET_BYTE;
         irq_overflow <= 1'b0;
         irq_compare_a <= 1'b0;
         irq_compare_b <= 1'b0;
         irq_capture <= 1'b0;
         compare_output_a <= 1'b0;
         compare_output_b <= 1'b0;
         io_rdata <= `RESET_BYTE;
      end else begin
         // RL7 RL24
         timer_flag_register <= (timer_flag_register & ~(flag_wr ? io_wdata : 8'h00)) | set_vec;
         irq_overflow <= timer_flag_register[`BIT_OVF] & timer_mask_register[`BIT_OVF]; // RL20
         irq_compare_a <= timer_flag_register[`BIT_CMPA] & timer_mask_register[`BIT_CMPA];
         irq_compare_b <= timer_flag_register[`BIT_CMPB] & timer_mask_register[`BIT_CMPB];
         irq_capture <= timer_flag_register[`BIT_CAP] & timer_mask_register[`BIT_CAP];
         // simple fast pwm: output high below compare; A idles when it sets top in modes 9, 11, 15
         compare_output_a <= !top_from_a && (counter_value16 < compare_register_a); // RL8 RL13
         compare_output_b <= (counter_value16 < compare_register_b); // RL8
         case (io_addr)
            `ADDR_CNT_L: io_rdata <= counter_value16[7:0];
            `ADDR_CMPA_L: io_rdata <= compare_register_a[7:0];
            `ADDR_CMPB_L: io_rdata <= compare_register_b[7:0];
            `ADDR_CAP_L: io_rdata <= capture_register[7:0];
            `ADDR_CNT_H, `ADDR_CAP_H: io_rdata <= temp_high; // RL14
            `ADDR_CMPA_H: io_rdata <= compare_register_a[15:8]; // RL17
            `ADDR_CMPB_H: io_rdata <= compare_register_b[15:8]; // RL17
            `ADDR_CTRL_A: io_rdata <= timer_control_a;
            `ADDR_CTRL_B: io_rdata <= timer_control_b;
            `ADDR_MASK: io_rdata <= timer_mask_register;
            `ADDR_FLAG: io_rdata <= timer_flag_register;
            `ADDR_SFIO: io_rdata <= {special_function_io_control[7:5], 1'b0,
                                     special_function_io_control[3:1], 1'b0}; // RL3
            default: io_rdata <= `RESET_BYTE;
         endcase
      end
   end
endmodule // timer16_front

// ---- timer16_defines.vh ----
// constants for the 16-bit timer front-end
// Behaviour
// RL1: writing one resets the shared prescaler
// RL2: reset bit clears itself after the reset
// RL3: writing zero ignored, bit reads zero
// RL4: prescaler reset restarts both timers' periods
// RL5: tick from prescaler taps or external pin
// RL6: no clock selected keeps counter frozen
// RL7: compare registers matched continuously, set flags
// RL8: compare results drive PWM outputs
// RL9: capture event copies counter to capture register; here no copy in modes 9, 11 and 12 to 15
// RL10: noise filter on the capture input
// RL11: bottom is 0x0000, max is 0xFFFF
// RL12: top fixed, compare A or capture register
// RL13: compare A as top: no PWM, buffered; here top follows cmp_a_buf unbuffered, and mode 4 still drives output A
// RL14: one shared high-byte temporary register
// RL15: low write loads low and temp together
// RL16: low read copies high byte to temp
// RL17: compare high reads bypass temp
// RL18: processor writes high first, reads low first
// RL19: processor guards two-byte access from interrupts
// RL20: four flags, each individually masked
// RL21: control registers plain 8-bit, any order
// RL22: prescaler taps 8, 64, 256, 1024
// RL23: external select 7 rising, 6 falling
// RL24: capture flag set with capture copy; here also set without a copy in modes 9, 11 and 12 to 15
// RL25: high-byte write only stores temp
`ifndef TIMER16_DEFINES_VH
`define TIMER16_DEFINES_VH
// ----------------------------------------
// register addresses (io space, choice)
// ----------------------------------------
`define ADDR_SFIO 6'h30
`define ADDR_CTRL_A 6'h2F
`define ADDR_CTRL_B 6'h2E
`define ADDR_CNT_H 6'h2D
`define ADDR_CNT_L 6'h2C
`define ADDR_CMPA_H 6'h2B
`define ADDR_CMPA_L 6'h2A
`define ADDR_CMPB_H 6'h29
`define ADDR_CMPB_L 6'h28
`define ADDR_CAP_H 6'h27
`define ADDR_CAP_L 6'h26
`define ADDR_MASK 6'h39
`define ADDR_FLAG 6'h38
// ----------------------------------------
// fields
// ----------------------------------------
`define BIT_PSR 0
`define BIT_OVF 2
`define BIT_CMPB 3
`define BIT_CMPA 4
`define BIT_CAP 5
`define BIT_ICES 6
`define BIT_ICNC 7
`define CS_NONE 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
`define BOTTOM 16'h0000
`define MAX 16'hFFFF
`define TOP_8 16'h00FF
`define TOP_9 16'h01FF
`define TOP_10 16'h03FF
`define RESET_BYTE 8'h00
`define FILTER_LEN 4
`endif

// ---- shared_prescaler.v ----
// free-running prescaler shared by the timers
`timescale 1ns/1ps
module shared_prescaler (
   input wire clock,
   input wire rst,
   input wire restart,
   output wire tap8,
   output wire tap64,
   output wire tap256,
   output wire tap1024
);
   reg [9:0] count;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         count <= 10'h000;
      end else if (restart) begin
         count <= 10'h000; // RL1 RL4
      end else begin
         count <= count + 10'h001;
      end
   end
   // taps pulse once per period, on the last count
   assign tap8 = (count[2:0] == 3'h7); // RL22
   assign tap64 = (count[5:0] == 6'h3F); // RL22
   assign tap256 = (count[7:0] == 8'hFF); // RL22
   assign tap1024 = (count == 10'h3FF); // RL22
endmodule // shared_prescaler

// ---- capture_filter.v ----
// capture input conditioner with optional noise filter and edge detect
`timescale 1ns/1ps
module capture_filter #(
   parameter LEN = 4
) (
   input wire clock,
   input wire rst,
   input wire level_in,
   input wire filter_on,
   input wire rising,
   output wire event_out
);
   reg [LEN-1:0] hist;
   reg clean;
   reg clean_q;
   wire all_one = &hist;
   wire all_zero = ~|hist;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         hist <= {LEN{1'b0}};
         clean <= 1'b0;
         clean_q <= 1'b0;
      end else begin
         hist <= {hist[LEN-2:0], level_in};
         // with filter_on, level accepted only after LEN equal samples; else after one
         if (!filter_on) begin
            clean <= hist[0];
         end else if (all_one) begin
            clean <= 1'b1; // RL10
         end else if (all_zero) begin
            clean <= 1'b0; // RL10
         end
         clean_q <= clean;
      end
   end
   assign event_out = rising ? (clean & ~clean_q) : (~clean & clean_q);
endmodule // capture_filter

// ---- timer16_front_monitor.sv ----
// port checker for the 16-bit timer front-end
`timescale 1ns/1ps
`include "timer16_defines.vh"
module timer16_front_monitor (
   input wire clock,
   input wire rst,
   input wire [5:0] io_addr,
   input wire io_wr,
   input wire [7:0] io_wdata,
   input wire [7:0] io_rdata,
   input wire [7:0] timer_flag_register,
   input wire [7:0] timer_mask_register,
   input wire [7:0] special_function_io_control,
   input wire irq_overflow,
   input wire irq_compare_a,
   input wire irq_compare_b,
   input wire irq_capture
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   sequence mask_write;
      io_wr && io_addr == `ADDR_MASK;
   endsequence
   sequence sfio_addressed;
      !io_wr && io_addr == `ADDR_SFIO;
   endsequence
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_SFIO_BIT0: assert property (special_function_io_control[0] == 1'b0)
      else $error("prescaler reset bit seen set");
   AST_SFIO_READ: assert property (sfio_addressed |=> io_rdata[0] == 1'b0)
      else $error("prescaler reset bit read as one");
   AST_SFIO_HOLD: assert property (!(io_wr && io_addr == `ADDR_SFIO) |=>
      $stable(special_function_io_control)) else $error("control byte moved without write");
   AST_MASK_WRITE: assert property (mask_write |=> timer_mask_register == $past(io_wdata))
      else $error("mask write not stored");
   AST_IRQ_OVF: assert property (irq_overflow == $past(timer_flag_register[2]
      & timer_mask_register[2])) else $error("overflow request wrong");
   AST_IRQ_CMPA: assert property (!(timer_flag_register[4] && timer_mask_register[4])
      |=> !irq_compare_a) else $error("compare a request unmasked");
   AST_IRQ_CMPB: assert property (timer_flag_register[3] && timer_mask_register[3]
      |=> irq_compare_b) else $error("compare b request missing");
   AST_IRQ_CAP: assert property ($rose(irq_capture) |-> $past(timer_flag_register[5])
      && $past(timer_mask_register[5])) else $error("capture request without cause");
endmodule // timer16_front_monitor
bind timer16_front timer16_front_monitor mon (.clock, .rst, .io_addr, .io_wr, .io_wdata,
   .io_rdata, .timer_flag_register, .timer_mask_register, .special_function_io_control,
   .irq_overflow, .irq_compare_a, .irq_compare_b, .irq_capture);

// ---- cpu_bus_model.sv ----
// processor-side model issuing byte accesses on the io bus
`timescale 1ns/1ps
module cpu_bus_model (
   input wire clock,
   input wire [7:0] io_rdata,
   output logic [5:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata
);
   initial begin
      io_addr = 6'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      io_addr <= a;
      io_wr <= 1'b1;
      io_wdata <= d;
      @(posedge clock);
      io_wr <= 1'b0;
      // released data must not keep looking valid
      io_wdata <= ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clock);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clock);
      io_rd <= 1'b0;
      #1 d = io_rdata;
   endtask
   // one caller at a time, so no access splits another's byte pair
   task automatic wr16(input logic [5:0] hi, input logic [15:0] v);
      wr(hi, v[15:8]);
      wr(hi - 6'h01, v[7:0]);
   endtask
   task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
      rd(lo, v[7:0]);
      rd(lo + 6'h01, v[15:8]);
   endtask
endmodule // cpu_bus_model

// ---- test_timer16_access_and_prescaler_reset.sv ----
// self-checking bench for the 16-bit timer front-end
`timescale 1ns/1ps
`include "timer16_defines.vh"
module test_timer16_access_and_prescaler_reset;
   logic clock, rst, ext_pin, cap_pin, cmp_out, cap_sel, io_wr, io_rd;
   logic irq_o, irq_a, irq_b, irq_c, out_a, out_b;
   logic [5:0] io_addr;
   logic [7:0] io_wdata, io_rdata, flags, mask, sfio, b;
   logic [15:0] w;
   int fail_count = 0;
   int checks = 0;
   cpu_bus_model bus (.clock, .io_rdata, .io_addr, .io_wr, .io_rd, .io_wdata);
   timer16_front DUT (.clock, .rst, .io_addr, .io_wr, .io_rd, .io_wdata,
      .external_timer_clock_pin(ext_pin), .capture_input_pin(cap_pin),
      .comparator_out(cmp_out), .capture_from_comparator(cap_sel), .io_rdata,
      .compare_output_a(out_a), .compare_output_b(out_b), .timer_flag_register(flags),
      .timer_mask_register(mask), .special_function_io_control(sfio),
      .irq_overflow(irq_o), .irq_compare_a(irq_a), .irq_compare_b(irq_b), .irq_capture(irq_c));
   // ----------------------------------------
   // compare and closing
   // ----------------------------------------
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", fail_count, checks);
      if (fail_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_sfio;
      check8(sfio, 8'h00);
      bus.rd(`ADDR_MASK, b);
      check8(b, 8'h00);
      bus.wr(`ADDR_SFIO, 8'h01);
      bus.rd(`ADDR_SFIO, b);
      check8(b, 8'h00);
      bus.wr(`ADDR_SFIO, 8'h0f);
      bus.rd(`ADDR_SFIO, b);
      check8(b, 8'h0e);
      bus.wr(`ADDR_SFIO, 8'h00);
   endtask
   task automatic t_access;
      bus.wr16(`ADDR_CNT_H, 16'h1234);
      bus.rd16(`ADDR_CNT_L, w);
      check16(w, 16'h1234);
      bus.wr(`ADDR_CNT_H, 8'h55);
      bus.rd16(`ADDR_CNT_L, w);
      check16(w, 16'h1234);
      bus.wr16(`ADDR_CMPA_H, 16'habcd);
      bus.wr(`ADDR_CNT_H, 8'h77);
      bus.rd(`ADDR_CMPA_H, b);
      check8(b, 8'hab);
      bus.rd(`ADDR_CNT_H, b);
      check8(b, 8'h77);
      bus.wr(`ADDR_CNT_H, 8'h66);
      bus.wr(`ADDR_CTRL_A, 8'h00);
      bus.wr(`ADDR_CNT_L, 8'h01);
      bus.rd16(`ADDR_CNT_L, w);
      check16(w, 16'h6601);
   endtask
   task automatic t_compare;
      bus.wr16(`ADDR_CNT_H, 16'h0000);
      bus.wr16(`ADDR_CMPB_H, 16'h0010);
      bus.wr(`ADDR_MASK, 8'h08);
      @(posedge clock);
      #1;
      check8(mask, 8'h08);
      check8({6'h00, out_a, out_b}, 8'h03);
      bus.wr(`ADDR_CTRL_B, {5'h00, `CS_DIV1});
      repeat (40) @(posedge clock);
      bus.wr(`ADDR_CTRL_B, 8'h00);
      bus.rd(`ADDR_FLAG, b);
      check8(b & 8'h18, 8'h08);
      check8({7'h00, irq_b}, 8'h01);
      bus.wr(`ADDR_FLAG, 8'h08);
      bus.rd(`ADDR_FLAG, b);
      check8(b & 8'h18, 8'h00);
      check8({7'h00, out_b}, 8'h00);
      // mode 15: compare a sets top and must not drive its output
      bus.wr(`ADDR_CTRL_A, 8'h03);
      bus.wr(`ADDR_CTRL_B, 8'h18);
      repeat (2) @(posedge clock);
      #1;
      check8({7'h00, out_a}, 8'h00);
      bus.wr(`ADDR_CTRL_B, 8'h00);
      bus.wr(`ADDR_CTRL_A, 8'h00);
   endtask
   task automatic t_presc;
      // restart puts the first divide-by-8 tick seven cycles away
      bus.wr16(`ADDR_CNT_H, 16'h0000);
      bus.wr(`ADDR_SFIO, 8'h01);
      bus.wr(`ADDR_CTRL_B, {5'h00, `CS_DIV8});
      repeat (4) @(posedge clock);
      bus.wr(`ADDR_CTRL_B, 8'h00);
      bus.rd16(`ADDR_CNT_L, w);
      check16(w, 16'h0000);
      bus.wr(`ADDR_SFIO, 8'h01);
      bus.wr(`ADDR_CTRL_B, {5'h00, `CS_DIV8});
      repeat (5) @(posedge clock);
      bus.wr(`ADDR_CTRL_B, 8'h00);
      bus.rd16(`ADDR_CNT_L, w);
      check16(w, 16'h0001);
   endtask
   task automatic t_ext;
      logic [2:0] sel;
      for (int i = 0; i < 2; i++) begin
         sel = i ? `CS_EXT_FALL : `CS_EXT_RISE;
         bus.wr16(`ADDR_CNT_H, 16'h0000);
         bus.wr(`ADDR_CTRL_B, {5'h00, sel});
         repeat (3) begin
            repeat (4) @(posedge clock);
            ext_pin <= 1'b1;
            repeat (4) @(posedge clock);
            ext_pin <= 1'b0;
         end
         repeat (6) @(posedge clock);
         bus.wr(`ADDR_CTRL_B, 8'h00);
         bus.rd16(`ADDR_CNT_L, w);
         check16(w, 16'h0003);
      end
   endtask
   task automatic t_capture;
      bus.wr16(`ADDR_CNT_H, 16'h0abc);
      bus.wr(`ADDR_CTRL_B, 8'hc0);
      @(posedge clock);
      cap_pin <= 1'b1;
      repeat (2) @(posedge clock);
      cap_pin <= 1'b0;
      // a two-cycle spike must die in the four-sample filter
      repeat (10) @(posedge clock);
      bus.rd(`ADDR_FLAG, b);
      check8(b & 8'h20, 8'h00);
      cap_pin <= 1'b1;
      repeat (12) @(posedge clock);
      bus.rd(`ADDR_FLAG, b);
      check8(b & 8'h20, 8'h20);
      bus.rd16(`ADDR_CAP_L, w);
      check16(w, 16'h0abc);
      bus.wr(`ADDR_FLAG, 8'h20);
      bus.wr(`ADDR_CTRL_B, 8'h40);
      bus.wr16(`ADDR_CNT_H, 16'h0123);
      cap_sel <= 1'b1;
      repeat (2) @(posedge clock);
      cmp_out <= 1'b1;
      repeat (8) @(posedge clock);
      bus.rd16(`ADDR_CAP_L, w);
      check16(w, 16'h0123);
   endtask
   // ----------------------------------------
   // run
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      stop_test;
   end
   initial begin
      rst = 1'b1;
      ext_pin = 1'b0;
      cap_pin = 1'b0;
      cmp_out = 1'b0;
      cap_sel = 1'b0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      t_sfio;
      t_access;
      t_compare;
      t_presc;
      t_ext;
      t_capture;
      stop_test;
   end
endmodule // test_timer16_access_and_prescaler_reset
